/* hw/ssi_pkg.sv */
// shared constants and state types for the sensor two-wire target port
`default_nettype none
package ssi_pkg;
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int US_CYCLES = SYS_CLK_HZ / 1_000_000;
  localparam int I2C_FAST_HZ = 400_000;
  localparam int I2C_SLOW_HZ = 100_000;
  // least SCL period, rounded up to whole cycles
  localparam int FAST_CYC = (SYS_CLK_HZ + I2C_FAST_HZ - 1) / I2C_FAST_HZ;
  localparam int SLOW_CYC = (SYS_CLK_HZ + I2C_SLOW_HZ - 1) / I2C_SLOW_HZ;
  localparam int STARTUP_US = 10_000;
  localparam int PRESS_W = 14;
  localparam int TEMP_W = 11;
  localparam int PERIOD_W = 18;
  localparam logic [1:0] STATUS_VALID = 2'h0;
  localparam logic [1:0] STATUS_STALE = 2'h2;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_AACK = 6'h04,
    ST_TX = 6'h08,
    ST_MACK = 6'h10,
    ST_IGN = 6'h20
  } ssi_state_t;

  typedef struct packed {
    ssi_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [1:0] bidx;
    logic rw;
    logic acked;
    logic oe;
    logic fail;
    logic clk_seen;
    logic [PRESS_W-1:0] press;
    logic [TEMP_W-1:0] temp;
    logic stale;
    logic irq;
    logic meas;
    logic [6:0] us_div;
    logic [PERIOD_W-1:0] us_cnt;
    logic [13:0] boot_cnt;
    logic booted;
    logic [9:0] spd_cnt;
    logic overspeed;
    logic cfg_ld;
    logic [6:0] addr;
    logic i2c_sel;
    logic sleep;
    logic slow;
    logic [PERIOD_W-1:0] period;
  } ssi_regs_t;

  localparam ssi_regs_t REGS_RST = '{st: ST_IDLE, stale: 1'b1, default: '0};
endpackage : ssi_pkg
`default_nettype wire

/* hw/ssi_pin_sync.sv */
// two-flop synchronisers with edge detect for the bus pins
`default_nettype none
module ssi_pin_sync #(
  parameter int N = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // raw pins
  input wire logic [N-1:0] din,
  // synchronised level and edges
  output logic [N-1:0] lvl,
  output logic [N-1:0] rise,
  output logic [N-1:0] fall
);
  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;
  logic [N-1:0] prev_r;

  // pins idle high on a pulled-up bus
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r <= '1;
      sync_r <= '1;
      prev_r <= '1;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign lvl = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;
endmodule : ssi_pin_sync
`default_nettype wire

/* hw/ssi_top.sv */
// two-wire target port, mode control and output data of the pressure sensor
`default_nettype none
module ssi_top #(
  parameter int STARTUP_TIME_US = ssi_pkg::STARTUP_US
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bus pins, data is open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic int_out,
  // locked configuration
  input wire logic [6:0] cfg_addr,
  input wire logic cfg_i2c_sel,
  input wire logic cfg_sleep_mode,
  input wire logic cfg_slow_clk,
  input wire logic [ssi_pkg::PERIOD_W-1:0] cfg_update_us,
  // measurement pipeline
  output logic meas_start,
  input wire logic res_valid,
  input wire logic [ssi_pkg::PRESS_W-1:0] res_press,
  input wire logic [ssi_pkg::TEMP_W-1:0] res_temp,
  // status
  output logic booted,
  output logic data_stale,
  output logic bus_overspeed
);
  import ssi_pkg::*;

  ssi_regs_t r;
  ssi_regs_t n;
  logic [1:0] lvl;
  logic [1:0] rise;
  logic [1:0] fall;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic tick;
  logic en;
  logic [7:0] nb;

  // pins come from another domain, two flops before use
  ssi_pin_sync #(.N(2)) u_sync (
    .clock(clock),
    .rst(rst),
    .din({scl_in, sda_in}),
    .lvl(lvl),
    .rise(rise),
    .fall(fall)
  );

  assign scl_s = lvl[1];
  assign sda_s = lvl[0];
  assign scl_rise = rise[1];
  assign scl_fall = fall[1];
  assign start_ev = fall[0] & scl_s;
  assign stop_ev = rise[0] & scl_s;

  function automatic logic [7:0] tx_byte(input logic [1:0] idx, input ssi_regs_t s);
    case (idx)
      2'h0: tx_byte = {(s.stale ? STATUS_STALE : STATUS_VALID), s.press[13:8]};
      2'h1: tx_byte = s.press[7:0];
      2'h2: tx_byte = s.temp[10:3];
      default: tx_byte = {s.temp[2:0], 5'h00};
    endcase
  endfunction : tx_byte

  always_comb begin
    n = r;
    n.meas = 1'b0;
    nb = 8'h00;
    tick = (r.us_div == 7'(US_CYCLES - 1));
    n.us_div = tick ? 7'h00 : 7'(r.us_div + 7'h01);
    // configuration caught once after reset, never again
    if (!r.cfg_ld) begin
      n.cfg_ld = 1'b1;
      n.addr = cfg_addr;
      n.i2c_sel = cfg_i2c_sel;
      n.sleep = cfg_sleep_mode;
      n.slow = cfg_slow_clk;
      n.period = cfg_update_us;
    end
    // first conversion after the start-up interval, in both modes
    if (!r.booted && tick) begin
      if (r.boot_cnt == 14'(STARTUP_TIME_US - 1)) begin
        n.booted = 1'b1;
        n.meas = 1'b1;
      end else begin
        n.boot_cnt = 14'(r.boot_cnt + 14'h0001);
      end
    end
    if (r.booted && !r.sleep && tick) begin
      if (18'(r.us_cnt + 18'h0_0001) >= r.period) begin
        n.us_cnt = '0;
        n.meas = 1'b1;
      end else begin
        n.us_cnt = 18'(r.us_cnt + 18'h0_0001);
      end
    end
    // scl period check; slow core clock caps the bus at the lower rate
    if (r.spd_cnt != 10'h3FF) begin
      n.spd_cnt = 10'(r.spd_cnt + 10'h001);
    end
    if (scl_rise) begin
      if (r.clk_seen && r.spd_cnt < (r.slow ? 10'(SLOW_CYC) : 10'(FAST_CYC))) begin
        n.overspeed = 1'b1;
      end
      n.spd_cnt = '0;
      n.clk_seen = 1'b1;
    end
    // spi role of the pins is handled elsewhere; target stays silent then
    en = r.i2c_sel && r.booted;
    case (r.st)
      ST_ADDR: begin
        if (scl_rise) begin
          n.sh = {r.sh[6:0], sda_s};
          n.cnt = 4'(r.cnt + 4'h1);
        end else if (scl_fall && r.cnt == 4'h8) begin
          if (en && r.sh[7:1] == r.addr) begin
            n.rw = r.sh[0];
            n.oe = 1'b1;
            n.st = ST_AACK;
          end else begin
            n.st = ST_IGN;
          end
        end
      end
      ST_AACK: begin
        if (scl_fall) begin
          n.cnt = 4'h0;
          if (r.rw) begin
            nb = tx_byte(2'h0, r);
            n.tx = nb;
            n.oe = ~nb[7];
            n.bidx = 2'h1;
            n.st = ST_TX;
          end else begin
            // measurement request only starts a conversion in sleep mode
            n.oe = 1'b0;
            n.meas = n.meas | r.sleep;
            n.st = ST_IGN;
          end
        end
      end
      ST_TX: begin
        if (scl_rise) begin
          n.cnt = 4'(r.cnt + 4'h1);
        end else if (scl_fall) begin
          if (r.cnt == 4'h8) begin
            n.oe = 1'b0;
            n.st = ST_MACK;
          end else begin
            n.tx = {r.tx[6:0], 1'b0};
            n.oe = ~r.tx[6];
          end
        end
      end
      ST_MACK: begin
        if (scl_rise) begin
          n.acked = ~sda_s;
          if (r.bidx == 2'h1) begin
            n.stale = 1'b1;
            n.irq = 1'b0;
          end
        end else if (scl_fall) begin
          if (r.acked) begin
            nb = tx_byte(r.bidx, r);
            n.tx = nb;
            n.oe = ~nb[7];
            n.bidx = (r.bidx == 2'h3) ? 2'h3 : 2'(r.bidx + 2'h1);
            n.cnt = 4'h0;
            n.st = ST_TX;
          end else begin
            n.st = ST_IGN;
          end
        end
      end
      default: ;
    endcase
    // a start that comes before the stop of its frame lands here as a restart
    if (start_ev) begin
      n.cnt = 4'h0;
      n.sh = 8'h00;
      n.clk_seen = 1'b0;
      n.oe = 1'b0;
      if (r.st != ST_IDLE) begin
        n.st = ST_IGN;
      end else if (r.fail) begin
        n.st = ST_IGN;
        n.fail = 1'b0;
      end else begin
        n.st = ST_ADDR;
      end
    end else if (stop_ev) begin
      if (!r.clk_seen && r.st != ST_IDLE) begin
        n.fail = 1'b1;
      end
      n.oe = 1'b0;
      n.st = ST_IDLE;
    end
    // a new result wins over a read that marks stale in the same cycle
    if (res_valid) begin
      n.press = res_press;
      n.temp = res_temp;
      n.stale = 1'b0;
      n.irq = r.i2c_sel;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r <= REGS_RST;
    end else begin
      r <= n;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = r.oe;
  assign int_out = r.irq;
  assign meas_start = r.meas;
  assign booted = r.booted;
  assign data_stale = r.stale;
  assign bus_overspeed = r.overspeed;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_periodic;
    r.booted && !r.sleep && tick && 18'(r.us_cnt + 18'h0_0001) >= r.period |=> meas_start;
  endproperty
  a_periodic: assert property (p_periodic) else $error("periodic conversion missed");

  property p_sleep_on_demand;
    meas_start && $past(r.booted) && r.sleep |-> $past(r.st == ST_AACK) && !$past(r.rw);
  endproperty
  a_sleep_on_demand: assert property (p_sleep_on_demand) else $error("unrequested conversion");

  property p_spi_silent;
    r.cfg_ld && !r.i2c_sel |-> !sda_oe && !int_out;
  endproperty
  a_spi_silent: assert property (p_spi_silent) else $error("two-wire pins active in spi role");

  property p_cfg_locked;
    r.cfg_ld && $past(r.cfg_ld) |-> $stable(r.addr) && $stable(r.i2c_sel) && $stable(r.sleep);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("configuration changed");

  property p_addr_match;
    $rose(r.st == ST_AACK) |-> r.sh[7:1] == r.addr && sda_oe;
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("ack for foreign address");

  property p_startstop_fail;
    r.st == ST_ADDR && stop_ev && !r.clk_seen |=> r.fail ##0 r.st == ST_IDLE;
  endproperty
  a_startstop_fail: assert property (p_startstop_fail) else $error("start-stop not flagged");

  property p_fail_eats_start;
    start_ev && r.fail && r.st == ST_IDLE |=> r.st == ST_IGN && !r.fail;
  endproperty
  a_fail_eats_start: assert property (p_fail_eats_start) else $error("failed frame served");

  property p_restart_fail;
    start_ev && r.st != ST_IDLE |=> r.st == ST_IGN && !sda_oe;
  endproperty
  a_restart_fail: assert property (p_restart_fail) else $error("restart frame served");

  property p_irq_rise;
    res_valid && r.i2c_sel |=> int_out && !data_stale;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("no interrupt on new data");

  property p_stale_after_read;
    r.st == ST_MACK && scl_rise && r.bidx == 2'h1 && !res_valid |=> data_stale && !int_out;
  endproperty
  a_stale_after_read: assert property (p_stale_after_read) else $error("stale not set");

  property p_overspeed;
    scl_rise && r.clk_seen && r.slow && r.spd_cnt < 10'(SLOW_CYC) |=> bus_overspeed;
  endproperty
  a_overspeed: assert property (p_overspeed) else $error("bus rate violation missed");

  c_read: cover property (r.st == ST_MACK && scl_fall && r.acked && r.bidx == 2'h3);
  c_request: cover property (meas_start && r.sleep && r.booted);
  // recovery frame lands far beyond a delay range, so a flag tracks it
  logic rec_wait_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rec_wait_r <= 1'b0;
    end else if (start_ev && r.fail && r.st == ST_IDLE) begin
      rec_wait_r <= 1'b1;
    end else if (r.st == ST_AACK) begin
      rec_wait_r <= 1'b0;
    end
  end
  c_recover: cover property (rec_wait_r && r.st == ST_AACK);
endmodule : ssi_top
`default_nettype wire

/* bench/ssi_host_model.sv */
// behavioural two-wire bus master for the sensor port
`default_nettype none
module ssi_host_model #(
  parameter int Q = 63
) (
  // clock
  input wire logic clock,
  // bus, sda_low high pulls data low
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task q;
    repeat (Q) @(posedge clock);
  endtask : q
  // 4*Q cycles a bit keeps scl at the fast limit
  task start;
    sda_low <= 1'b0;
    q;
    scl <= 1'b1;
    q;
    sda_low <= 1'b1;
    q;
    scl <= 1'b0;
    q;
  endtask : start
  // start leaves data low, so a leading 0 bit makes no fall
  task bit_io(input logic b, output logic r);
    sda_low <= ~b;
    q;
    scl <= 1'b1;
    q;
    r = sda;
    q;
    scl <= 1'b0;
    q;
  endtask : bit_io
  task byte_io(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
  endtask : byte_io
  task stop;
    sda_low <= 1'b1;
    q;
    scl <= 1'b1;
    q;
    sda_low <= 1'b0;
    q;
  endtask : stop
  // start then stop with no clock pulse; next frame must fail
  task blip;
    sda_low <= 1'b1;
    q;
    sda_low <= 1'b0;
    q;
  endtask : blip
endmodule : ssi_host_model
`default_nettype wire

/* bench/ssi_top_test.sv */
// self-checking bench for the sensor two-wire target port
`default_nettype none
module ssi_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import ssi_pkg::*;
  localparam logic [6:0] ADDR = 7'h28;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_low, sda_out, sda_oe, int_out, meas_start, booted, data_stale, bus_overspeed;
  logic res_valid = 1'b0;
  logic cfg_sleep = 1'b1;
  logic cfg_i2c = 1'b1;
  logic cfg_slow = 1'b0;
  logic [PRESS_W-1:0] res_press = '0;
  logic [TEMP_W-1:0] res_temp = '0;
  logic ack;
  wire logic sda;
  int errors = 0;
  int tests_run = 0;
  int n_meas = 0;
  // pull-up: high unless the host pulls or the target drives its value
  assign sda = sda_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);
  ssi_top #(.STARTUP_TIME_US(5)) dut_u (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .int_out(int_out), .cfg_addr(ADDR),
    .cfg_i2c_sel(cfg_i2c), .cfg_sleep_mode(cfg_sleep), .cfg_slow_clk(cfg_slow),
    .cfg_update_us(18'h0_000a), .meas_start(meas_start), .res_valid(res_valid),
    .res_press(res_press), .res_temp(res_temp), .booted(booted), .data_stale(data_stale),
    .bus_overspeed(bus_overspeed));
  ssi_host_model m_u (.clock(clock), .scl(scl), .sda_low(sda_low), .sda(sda));
  always #5 clock = ~clock;
  always @(posedge clock) begin
    if (meas_start === 1'b1) n_meas++;
  end
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  task frame(input logic [6:0] a, input logic rw);
    logic [7:0] junk;
    logic nak;
    m_u.start;
    m_u.byte_io({a, rw}, junk);
    m_u.bit_io(1'b1, nak);
    ack = ~nak;
  endtask : frame
  task t_boot;
    for (int i = 0; i < 1000 && booted !== 1'b1; i++) @(posedge clock);
    #1;
    // commands only once start-up is over
    check("booted", 8'(booted), 8'h01);
    check("boot conversions", 8'(n_meas), 8'h01);
    $display("test boot done");
  endtask : t_boot
  task t_meas;
    int n0;
    n0 = n_meas;
    frame(ADDR, 1'b0);
    m_u.stop;
    check("request ack", 8'(ack), 8'h01);
    check("requested conversions", 8'(n_meas - n0), 8'h01);
    $display("test measure request done");
  endtask : t_meas
  task t_result;
    res_press <= 14'h1234;
    res_temp <= 11'h05a5;
    res_valid <= 1'b1;
    @(posedge clock);
    res_valid <= 1'b0;
    @(posedge clock);
    #1;
    check("int and stale", 8'({int_out, data_stale}), 8'h02);
    $display("test result done");
  endtask : t_result
  task t_read(input logic [7:0] e0);
    logic [7:0] b0, b1;
    logic x;
    frame(ADDR, 1'b1);
    m_u.byte_io(8'hff, b0);
    m_u.bit_io(1'b0, x);
    m_u.byte_io(8'hff, b1);
    m_u.bit_io(1'b1, x);
    m_u.stop;
    check("fetch ack", 8'(ack), 8'h01);
    check("status and high", b0, e0);
    check("pressure low", b1, 8'h34);
    check("int and stale after read", 8'({int_out, data_stale}), 8'h01);
    $display("test read done");
  endtask : t_read
  task t_other;
    frame(ADDR ^ 7'h01, 1'b0);
    m_u.stop;
    check("foreign address ack", 8'(ack), 8'h00);
    $display("test foreign address done");
  endtask : t_other
  task t_blip;
    m_u.blip;
    frame(ADDR, 1'b0);
    m_u.stop;
    check("after blip ack", 8'(ack), 8'h00);
    frame(ADDR, 1'b0);
    m_u.stop;
    check("recovery ack", 8'(ack), 8'h01);
    $display("test start-stop done");
  endtask : t_blip
  task t_restart;
    frame(ADDR, 1'b0);
    check("first ack", 8'(ack), 8'h01);
    // no stop: this start is a repeated one
    frame(ADDR, 1'b0);
    m_u.stop;
    check("restart frame ack", 8'(ack), 8'h00);
    frame(ADDR, 1'b0);
    m_u.stop;
    check("recovered ack", 8'(ack), 8'h01);
    check("overspeed", 8'(bus_overspeed), 8'h00);
    $display("test repeated start done");
  endtask : t_restart
  // mid-run reset into periodic mode on the slow core clock
  task t_periodic;
    int n0;
    rst <= 1'b1;
    cfg_sleep <= 1'b0;
    cfg_slow <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    check("reset again", 8'({booted, data_stale, bus_overspeed, int_out}), 8'h04);
    for (int i = 0; i < 1000 && booted !== 1'b1; i++) @(posedge clock);
    #1;
    n0 = n_meas;
    // boot pulse already counted; a 10 us period gives two in 25 us
    repeat (2500) @(posedge clock);
    check("periodic conversions", 8'(n_meas - n0), 8'h02);
    // fast bit rate is too quick for the slow core clock
    frame(ADDR, 1'b0);
    m_u.stop;
    check("slow clock ack", 8'(ack), 8'h01);
    check("slow clock overspeed", 8'(bus_overspeed), 8'h01);
    $display("test periodic done");
  endtask : t_periodic
  // mid-run reset into the spi role: port and interrupt stay quiet
  task t_spi;
    rst <= 1'b1;
    cfg_i2c <= 1'b0;
    cfg_sleep <= 1'b1;
    cfg_slow <= 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 1000 && booted !== 1'b1; i++) @(posedge clock);
    check("spi role booted", 8'(booted), 8'h01);
    frame(ADDR, 1'b1);
    m_u.stop;
    check("spi role ack", 8'(ack), 8'h00);
    res_press <= 14'h0abc;
    res_valid <= 1'b1;
    @(posedge clock);
    res_valid <= 1'b0;
    @(posedge clock);
    #1;
    check("spi role int and stale", 8'({int_out, data_stale}), 8'h00);
    $display("test spi role done");
  endtask : t_spi
  initial begin
    repeat (20) @(posedge clock);
    #1;
    check("reset outputs", 8'({booted, data_stale, sda_oe, int_out}), 8'h04);
    @(posedge clock);
    rst <= 1'b0;
    t_boot;
    t_meas;
    t_result;
    t_read(8'h12);
    t_read(8'h92);
    t_other;
    t_blip;
    t_restart;
    t_periodic;
    t_spi;
    finish_test;
  end
  // a hang is cut off well beyond the expected run of about 43000 cycles
  initial begin
    repeat (100000) @(posedge clock);
    errors++;
    finish_test;
  end
endmodule : ssi_top_test
`default_nettype wire
